/* File: rtl/hfc_pkg.sv */
// Shared constants and types for the HDLC frame classifier.
package hfc_pkg;

  // Line framing.
  localparam logic [7:0] HFC_FLAG = 8'h7e;
  localparam logic [2:0] HFC_STUFF_ONES = 3'h5;
  localparam logic [2:0] HFC_FLAG_ONES = 3'h6;
  localparam logic [2:0] HFC_ABORT_ONES = 3'h7;
  // A closing flag has put its leading zero and five ones into the data path before it is recognised.
  localparam int HFC_FLAG_LEAD = 6;
  localparam logic [2:0] HFC_LEAD_CNT = 3'h6;
  localparam logic [2:0] HFC_OCT_LAST_BIT = 3'h7;
  // Address, control and two check octets.
  localparam logic [2:0] HFC_MIN_OCTETS = 3'h4;

  // Field tags on the octet stream.
  localparam logic [2:0] TAG_ADDR = 3'h0;
  localparam logic [2:0] TAG_CTL = 3'h1;
  localparam logic [2:0] TAG_INFO = 3'h2;
  localparam logic [2:0] TAG_FCS = 3'h3;
  localparam logic [2:0] TAG_END = 3'h4;
  localparam int TAG_W = 3;

  // End-of-frame status word layout.
  localparam int END_SHORT_BIT = 7;
  localparam int END_ABORT_BIT = 6;
  localparam int END_RESID_LSB = 0;

  // Frame kinds and supervisory functions.
  localparam logic [1:0] KIND_I = 2'h0;
  localparam logic [1:0] KIND_S = 2'h1;
  localparam logic [1:0] KIND_U = 2'h2;
  localparam logic [1:0] SUP_RR = 2'h0;
  localparam logic [1:0] SUP_RNR = 2'h1;
  localparam logic [1:0] SUP_REJ = 2'h2;
  localparam logic [1:0] SUP_SREJ = 2'h3;
  localparam logic [1:0] LSB_SUP = 2'h1;
  localparam logic [1:0] LSB_UNN = 2'h3;

  // Unnumbered codes: control bits 7..5 then 3..0, poll/final removed.
  localparam logic [6:0] UC_SNRM = 7'h43;
  localparam logic [6:0] UC_SARM = 7'h0f;
  localparam logic [6:0] UC_SABM = 7'h1f;
  localparam logic [6:0] UC_SNRME = 7'h6f;
  localparam logic [6:0] UC_SARME = 7'h2f;
  localparam logic [6:0] UC_SABME = 7'h3f;
  localparam logic [6:0] UC_SIM = 7'h07;
  localparam logic [6:0] UC_DISC = 7'h23;
  localparam logic [6:0] UC_UI = 7'h03;
  localparam logic [6:0] UC_UP = 7'h13;
  localparam logic [6:0] UC_RSET = 7'h4f;
  localparam logic [6:0] UC_XID = 7'h5f;
  localparam logic [6:0] UC_UA = 7'h33;
  localparam logic [6:0] UC_FRMR = 7'h47;

  typedef enum logic [4:0] {
    UT_NONE, UT_SNRM, UT_SARM, UT_SABM, UT_SNRME, UT_SARME, UT_SABME, UT_SIM, UT_DISC,
    UT_UI, UT_UP, UT_RSET, UT_XID, UT_UA, UT_DM, UT_RIM, UT_FRMR, UT_RD
  } hfc_utype_t;

  typedef enum logic [1:0] {ST_HUNT, ST_RX, ST_FLUSH} hfc_state_t;

  localparam int HFC_FIFO_DEPTH = 8;
  localparam int HFC_WORD_W = 11;

endpackage

/* File: rtl/hfc_fifo.sv */
// Parameterised valid/ready FIFO held in flip-flops.
`timescale 1ns/10ps
module hfc_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
  } hfc_fifo_state_t;

  hfc_fifo_state_t cur;
  hfc_fifo_state_t nx;
  logic push;
  logic pop;

  assign in_ready = (cur.count != FULL);
  assign out_valid = (cur.count != '0);
  assign out_data = cur.mem[cur.rptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    nx = cur;
    if (push) begin
      nx.mem[cur.wptr] = in_data;
      nx.wptr = (cur.wptr == LAST) ? '0 : cur.wptr + 1'b1;
    end
    if (pop) begin
      nx.rptr = (cur.rptr == LAST) ? '0 : cur.rptr + 1'b1;
    end
    case ({push, pop})
      2'b10: nx.count = cur.count + 1'b1;
      2'b01: nx.count = cur.count - 1'b1;
      default: nx.count = cur.count;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= nx;
    end
  end

  a_fifo_bounds: assert property (@(posedge clk) disable iff (rst)
    cur.count <= FULL) else $error("FIFO count beyond depth.");
endmodule

/* File: rtl/hfc_frame_classifier.sv */
// Receive-side HDLC frame delimiter, field splitter and control-octet classifier.
`timescale 1ns/10ps
module hfc_frame_classifier #(
  parameter int FIFO_DEPTH = hfc_pkg::HFC_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic line_bit,
  input wire logic line_valid,
  output logic line_ready,
  input wire logic resp_dir,
  input wire logic trig_enable,
  input wire logic [7:0] trig_addr_val,
  input wire logic [7:0] trig_addr_care,
  input wire logic [7:0] trig_ctl_val,
  input wire logic [7:0] trig_ctl_care,
  output logic oct_valid,
  input wire logic oct_ready,
  output logic [hfc_pkg::TAG_W-1:0] oct_tag,
  output logic [7:0] oct_data,
  output logic ctl_strobe,
  output logic [1:0] ctl_kind,
  output logic [2:0] rx_seq,
  output logic [2:0] tx_seq,
  output logic pf_bit,
  output logic [1:0] sup_type,
  output hfc_pkg::hfc_utype_t un_type,
  output logic poll_flag,
  output logic final_flag,
  output logic trig_hit
);
  import hfc_pkg::*;

  typedef struct packed {
    hfc_state_t st;
    logic [7:0] sr;
    logic [2:0] ones;
    logic [HFC_FLAG_LEAD-1:0] dq;
    logic [2:0] dcnt;
    logic [7:0] asm_oct;
    logic [2:0] acnt;
    logic [7:0] hold0;
    logic [7:0] hold1;
    logic [1:0] hcnt;
    logic [2:0] ocnt;
    logic [1:0] ecnt;
    logic addr_hit;
    logic aborted;
    logic short_frame;
    logic [2:0] resid;
    logic pend_valid;
    logic [TAG_W-1:0] pend_tag;
    logic [7:0] pend_data;
    logic bit_ready;
    logic [7:0] ctl_oct;
    logic resp_q;
    logic ctl_strobe;
    logic [1:0] ctl_kind;
    logic [2:0] rx_seq;
    logic [2:0] tx_seq;
    logic pf_bit;
    logic [1:0] sup_type;
    hfc_utype_t un_type;
    logic poll_flag;
    logic final_flag;
    logic trig_hit;
    logic out_valid;
    logic [TAG_W-1:0] out_tag;
    logic [7:0] out_data;
  } hfc_state_rec_t;

  hfc_state_rec_t cur;
  hfc_state_rec_t nx;
  logic take;
  logic flag_seen;
  logic f_in_ready;
  logic f_out_valid;
  logic f_out_ready;
  logic [HFC_WORD_W-1:0] f_out_data;

  // Pattern compare where a clear care bit is don't-care.
  function automatic logic hfc_match(input logic [7:0] oct, input logic [7:0] val, input logic [7:0] care);
    hfc_match = ((oct ^ val) & care) == 8'h00;
  endfunction

  // Unnumbered type; bit 4 is dropped so poll/final never changes the type.
  function automatic hfc_utype_t hfc_unnum(input logic [7:0] c, input logic resp);
    logic [6:0] m;
    m = {c[7:5], c[3:0]};
    hfc_unnum = UT_NONE;
    if (!resp) begin
      case (m)
        UC_SNRM: hfc_unnum = UT_SNRM;
        UC_SARM: hfc_unnum = UT_SARM;
        UC_SABM: hfc_unnum = UT_SABM;
        UC_SNRME: hfc_unnum = UT_SNRME;
        UC_SARME: hfc_unnum = UT_SARME;
        UC_SABME: hfc_unnum = UT_SABME;
        UC_SIM: hfc_unnum = UT_SIM;
        UC_DISC: hfc_unnum = UT_DISC;
        UC_UI: hfc_unnum = UT_UI;
        UC_UP: hfc_unnum = UT_UP;
        UC_RSET: hfc_unnum = UT_RSET;
        UC_XID: hfc_unnum = UT_XID;
        default: hfc_unnum = UT_NONE;
      endcase
    end else begin
      case (m)
        UC_UA: hfc_unnum = UT_UA;
        UC_SARM: hfc_unnum = UT_DM;
        UC_SIM: hfc_unnum = UT_RIM;
        UC_UI: hfc_unnum = UT_UI;
        UC_FRMR: hfc_unnum = UT_FRMR;
        UC_XID: hfc_unnum = UT_XID;
        UC_DISC: hfc_unnum = UT_RD;
        default: hfc_unnum = UT_NONE;
      endcase
    end
  endfunction

  assign take = line_valid && cur.bit_ready;
  assign flag_seen = take && (cur.ones == HFC_FLAG_ONES) && !line_bit;
  assign f_out_ready = !cur.out_valid || oct_ready;

  always_comb begin
    logic dbit;
    logic have;
    logic [7:0] oct;
    dbit = 1'b0;
    have = 1'b0;
    oct = 8'h00;
    nx = cur;
    nx.ctl_strobe = 1'b0;
    nx.trig_hit = 1'b0;
    if (cur.pend_valid && f_in_ready) begin
      nx.pend_valid = 1'b0;
    end
    if (f_out_ready) begin
      nx.out_valid = f_out_valid;
      nx.out_tag = f_out_data[HFC_WORD_W-1 -: TAG_W];
      nx.out_data = f_out_data[7:0];
    end
    if (take) begin
      nx.sr = {line_bit, cur.sr[7:1]};
    end
    case (cur.st)
      ST_HUNT, ST_RX: begin
        if (take) begin
          if (cur.ones == HFC_STUFF_ONES && !line_bit) begin
            // Inserted zero after five ones is removed from the data.
            nx.ones = 3'h0;
          end else if (cur.ones == HFC_STUFF_ONES) begin
            nx.ones = HFC_FLAG_ONES;
          end else if (flag_seen) begin
            nx.ones = 3'h0;
            nx.dq = '0;
            nx.dcnt = 3'h0;
            nx.asm_oct = 8'h00;
            nx.acnt = 3'h0;
            if (cur.st == ST_HUNT || (cur.ocnt == 3'h0 && cur.acnt == 3'h0)) begin
              // Opening or shared idle flag: nothing to close.
              nx.st = ST_RX;
              nx.hcnt = 2'h0;
              nx.ecnt = 2'h0;
              nx.ocnt = 3'h0;
            end else begin
              nx.st = ST_FLUSH;
              nx.resid = cur.acnt;
              nx.short_frame = (cur.ocnt < HFC_MIN_OCTETS);
              nx.aborted = 1'b0;
            end
          end else if (cur.ones >= HFC_FLAG_ONES) begin
            // Seven or more ones abort the frame; the next zero restarts the count so a later flag is seen.
            nx.ones = line_bit ? HFC_ABORT_ONES : 3'h0;
            if (cur.st == ST_RX && (cur.ocnt != 3'h0 || cur.acnt != 3'h0)) begin
              nx.st = ST_FLUSH;
              nx.resid = cur.acnt;
              nx.short_frame = (cur.ocnt < HFC_MIN_OCTETS);
              nx.aborted = 1'b1;
            end else begin
              nx.st = ST_HUNT;
            end
          end else begin
            nx.ones = line_bit ? cur.ones + 1'b1 : 3'h0;
            if (cur.st == ST_RX) begin
              // Data is held back so that a closing flag's own bits never reach an octet.
              nx.dq = {line_bit, cur.dq[HFC_FLAG_LEAD-1:1]};
              if (cur.dcnt == HFC_LEAD_CNT) begin
                dbit = cur.dq[0];
                have = 1'b1;
              end else begin
                nx.dcnt = cur.dcnt + 1'b1;
              end
            end
          end
        end
        if (have) begin
          oct = {dbit, cur.asm_oct[7:1]};
          nx.asm_oct = oct;
          nx.acnt = cur.acnt + 1'b1;
          if (cur.acnt == HFC_OCT_LAST_BIT) begin
            nx.acnt = 3'h0;
            if (cur.ocnt != 3'h7) begin
              nx.ocnt = cur.ocnt + 1'b1;
            end
            if (cur.ocnt == 3'h0) begin
              nx.addr_hit = hfc_match(oct, trig_addr_val, trig_addr_care);
            end
            if (cur.ocnt == 3'h1) begin
              nx.ctl_oct = oct;
              nx.resp_q = resp_dir;
              nx.ctl_strobe = 1'b1;
              nx.trig_hit = trig_enable && cur.addr_hit && hfc_match(oct, trig_ctl_val, trig_ctl_care);
              nx.rx_seq = oct[7:5];
              nx.pf_bit = oct[4];
              nx.tx_seq = 3'h0;
              nx.sup_type = SUP_RR;
              nx.un_type = UT_NONE;
              nx.poll_flag = 1'b0;
              nx.final_flag = 1'b0;
              if (!oct[0]) begin
                nx.ctl_kind = KIND_I;
                nx.tx_seq = oct[3:1];
              end else if (oct[1:0] == LSB_SUP) begin
                nx.ctl_kind = KIND_S;
                nx.sup_type = oct[3:2];
              end else begin
                nx.ctl_kind = KIND_U;
                nx.un_type = hfc_unnum(oct, resp_dir);
                nx.poll_flag = !resp_dir && oct[4];
                nx.final_flag = resp_dir && oct[4];
              end
            end
            // Two octets stay held back until the next one proves they are not the check sequence.
            case (cur.hcnt)
              2'h0: begin
                nx.hold0 = oct;
                nx.hcnt = 2'h1;
              end
              2'h1: begin
                nx.hold1 = oct;
                nx.hcnt = 2'h2;
              end
              default: begin
                nx.pend_valid = 1'b1;
                nx.pend_data = cur.hold0;
                nx.pend_tag = (cur.ecnt == 2'h0) ? TAG_ADDR : (cur.ecnt == 2'h1) ? TAG_CTL : TAG_INFO;
                if (cur.ecnt != 2'h2) begin
                  nx.ecnt = cur.ecnt + 1'b1;
                end
                nx.hold0 = cur.hold1;
                nx.hold1 = oct;
              end
            endcase
          end
        end
      end
      ST_FLUSH: begin
        if (!cur.pend_valid) begin
          nx.pend_valid = 1'b1;
          if (cur.hcnt != 2'h0) begin
            nx.pend_tag = TAG_FCS;
            nx.pend_data = cur.hold0;
            nx.hold0 = cur.hold1;
            nx.hcnt = cur.hcnt - 1'b1;
          end else begin
            nx.pend_tag = TAG_END;
            nx.pend_data = 8'h00;
            nx.pend_data[END_SHORT_BIT] = cur.short_frame;
            nx.pend_data[END_ABORT_BIT] = cur.aborted;
            nx.pend_data[END_RESID_LSB +: 3] = cur.resid;
            nx.st = cur.aborted ? ST_HUNT : ST_RX;
            nx.ocnt = 3'h0;
            nx.ecnt = 2'h0;
            nx.addr_hit = 1'b0;
          end
        end
      end
      default: begin
        nx.st = ST_HUNT;
      end
    endcase
    // The line stalls while an octet waits, so the one-word staging slot never overflows.
    nx.bit_ready = (nx.st != ST_FLUSH) && !nx.pend_valid;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= nx;
    end
  end

  hfc_fifo #(
    .WIDTH(HFC_WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(cur.pend_valid),
    .in_ready(f_in_ready),
    .in_data({cur.pend_tag, cur.pend_data}),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );

  assign line_ready = cur.bit_ready;
  assign oct_valid = cur.out_valid;
  assign oct_tag = cur.out_tag;
  assign oct_data = cur.out_data;
  assign ctl_strobe = cur.ctl_strobe;
  assign ctl_kind = cur.ctl_kind;
  assign rx_seq = cur.rx_seq;
  assign tx_seq = cur.tx_seq;
  assign pf_bit = cur.pf_bit;
  assign sup_type = cur.sup_type;
  assign un_type = cur.un_type;
  assign poll_flag = cur.poll_flag;
  assign final_flag = cur.final_flag;
  assign trig_hit = cur.trig_hit;

  a_flag_pattern: assert property (@(posedge clk) disable iff (rst)
    flag_seen |=> cur.sr == HFC_FLAG) else $error("Flag accepted without 7e on the line.");
  a_flag_closes: assert property (@(posedge clk) disable iff (rst)
    (flag_seen && cur.st == ST_RX && cur.ocnt != 3'h0) |=> cur.st == ST_FLUSH) else $error("Closing flag ignored.");
  a_field_order: assert property (@(posedge clk) disable iff (rst)
    (cur.pend_valid && cur.pend_tag == TAG_CTL) |-> cur.ecnt == 2'h2) else $error("Control before address.");
  a_fcs_held: assert property (@(posedge clk) disable iff (rst)
    $rose(cur.st == ST_FLUSH) && $past(cur.hcnt) == 2'h2 |-> ##[1:3] (cur.pend_valid && cur.pend_tag == TAG_FCS))
    else $error("Check octets not tagged.");
  a_resid_report: assert property (@(posedge clk) disable iff (rst)
    ($rose(cur.pend_valid) && cur.pend_tag == TAG_END) |-> cur.pend_data[2:0] == cur.resid) else $error("Bit count lost.");
  a_i_fields: assert property (@(posedge clk) disable iff (rst)
    (ctl_strobe && !cur.ctl_oct[0]) |-> (ctl_kind == KIND_I && tx_seq == cur.ctl_oct[3:1] && pf_bit == cur.ctl_oct[4]))
    else $error("I frame fields wrong.");
  a_s_fields: assert property (@(posedge clk) disable iff (rst)
    (ctl_strobe && cur.ctl_oct[1:0] == LSB_SUP) |-> (ctl_kind == KIND_S && rx_seq == cur.ctl_oct[7:5]))
    else $error("S frame fields wrong.");
  a_s_function: assert property (@(posedge clk) disable iff (rst)
    (ctl_strobe && ctl_kind == KIND_S) |-> sup_type == cur.ctl_oct[3:2]) else $error("S function wrong.");
  a_u_kind: assert property (@(posedge clk) disable iff (rst)
    (ctl_strobe && cur.ctl_oct[1:0] == LSB_UNN) |-> ctl_kind == KIND_U) else $error("U frame missed.");
  a_poll_final: assert property (@(posedge clk) disable iff (rst)
    (ctl_strobe && ctl_kind == KIND_U) |-> (poll_flag == (!cur.resp_q && cur.ctl_oct[4])
      && final_flag == (cur.resp_q && cur.ctl_oct[4]))) else $error("Poll/final misread.");
  a_snrm_decode: assert property (@(posedge clk) disable iff (rst)
    (ctl_strobe && !cur.resp_q && {cur.ctl_oct[7:5], cur.ctl_oct[3:0]} == UC_SNRM) |-> un_type == UT_SNRM)
    else $error("SNRM not decoded.");
  a_trig_timing: assert property (@(posedge clk) disable iff (rst)
    trig_hit |-> (ctl_strobe && hfc_match(cur.ctl_oct, $past(trig_ctl_val), $past(trig_ctl_care))))
    else $error("Trigger without control match.");
endmodule

/* File: tb/hfc_line_station.sv */
// Line station model that sends bit-stuffed frames towards the classifier.
`timescale 1ns/10ps
module hfc_line_station (
  input wire logic clk,
  input wire logic line_ready,
  output logic line_bit,
  output logic line_valid
);
  import hfc_pkg::*;
  int gap = 0;
  int ones = 0;
  initial begin
    line_bit = 1'b0;
    line_valid = 1'b0;
  end
  // An idle line shows the inverse of the last bit, so a stale level never passes for data.
  task automatic idle();
    line_valid <= 1'b0;
    line_bit <= ~line_bit;
    @(posedge clk);
  endtask
  task automatic put_bit(input logic b, input logic stuff);
    line_bit <= b;
    line_valid <= 1'b1;
    do @(posedge clk); while (line_ready !== 1'b1);
    ones = b ? ones + 1 : 0;
    if (gap > 0) begin
      idle();
      repeat (gap - 1) @(posedge clk);
    end
    if (stuff && ones == 5) begin
      put_bit(1'b0, 1'b0);
    end
  endtask
  task automatic put_oct(input logic [7:0] v, input int n);
    for (int i = 0; i < n; i++) put_bit(v[i], 1'b1);
  endtask
  task automatic send_frame(input logic [7:0] o[$], input int rb, input logic [7:0] rv);
    put_oct(HFC_FLAG, 0);
    for (int i = 0; i < 8; i++) put_bit(HFC_FLAG[i], 1'b0);
    foreach (o[i]) put_oct(o[i], 8);
    put_oct(rv, rb);
    for (int i = 0; i < 8; i++) put_bit(HFC_FLAG[i], 1'b0);
    idle();
  endtask
endmodule

/* File: tb/hfc_frame_classifier_bench.sv */
// Self-checking bench for the HDLC frame classifier.
`timescale 1ns/10ps
module hfc_frame_classifier_bench;
  import hfc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic resp_dir = 1'b0;
  logic trig_enable = 1'b1;
  logic oct_ready = 1'b1;
  logic [7:0] ta_val = 8'h00, ta_care = 8'h00, tc_val = 8'h00, tc_care = 8'h00;
  logic line_bit, line_valid, line_ready, oct_valid, ctl_strobe, pf_bit, poll_flag, final_flag, trig_hit;
  logic [2:0] oct_tag, rx_seq, tx_seq;
  logic [7:0] oct_data;
  logic [1:0] ctl_kind, sup_type;
  hfc_utype_t un_type;
  logic [10:0] words[$];
  logic [7:0] q[$];
  int strobes, hits, cycles, bad_count, total_checks;
  always #5 clk = ~clk;
  hfc_frame_classifier hfc_frame_classifier_i(.clk(clk), .rst(rst), .line_bit(line_bit),
    .line_valid(line_valid), .line_ready(line_ready), .resp_dir(resp_dir), .trig_enable(trig_enable),
    .trig_addr_val(ta_val), .trig_addr_care(ta_care), .trig_ctl_val(tc_val), .trig_ctl_care(tc_care),
    .oct_valid(oct_valid), .oct_ready(oct_ready), .oct_tag(oct_tag), .oct_data(oct_data),
    .ctl_strobe(ctl_strobe), .ctl_kind(ctl_kind), .rx_seq(rx_seq), .tx_seq(tx_seq), .pf_bit(pf_bit),
    .sup_type(sup_type), .un_type(un_type), .poll_flag(poll_flag), .final_flag(final_flag),
    .trig_hit(trig_hit));
  hfc_line_station hfc_line_station_i(.clk(clk), .line_ready(line_ready), .line_bit(line_bit),
    .line_valid(line_valid));
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (oct_valid === 1'b1 && oct_ready === 1'b1) words.push_back({oct_tag, oct_data});
    if (ctl_strobe === 1'b1) strobes++;
    if (trig_hit === 1'b1) hits++;
    if (cycles == 80000) begin
      bad_count++;
      test_done();
    end
  end
  task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wait_end();
    for (int i = 0; i < 3000 && !(words.size() > 0 && words[$][10:8] === TAG_END); i++) @(posedge clk);
    if (words.size() == 0 || words[$][10:8] !== TAG_END) begin
      bad_count++;
      $display("[ERR] %0t end of frame not seen", $time);
    end
    if (words.size() == 0) words.push_back(11'h0);
  endtask
  task automatic run(input int rb);
    words.delete();
    strobes = 0;
    hits = 0;
    hfc_line_station_i.send_frame(q, rb, 8'h05);
    wait_end();
  endtask
  // Expected words follow the field order: address, control, information, two check octets, end.
  task automatic exp_stream(input logic [7:0] endw);
    int n;
    n = q.size();
    chk(11'(words.size()), 11'(n + 1), "word count");
    for (int i = 0; i < n && i < words.size(); i++) begin
      chk(words[i], {(i == 0) ? TAG_ADDR : (i == 1) ? TAG_CTL : (i < n - 2) ? TAG_INFO : TAG_FCS, q[i]}, "word");
    end
    chk(words[$], {TAG_END, endw}, "end word");
  endtask
  task automatic t_info();
    tc_val <= 8'h22;
    tc_care <= 8'hff;
    q = '{8'h03, 8'h22, 8'h7e, 8'hff, 8'h12, 8'h34};
    run(0);
    exp_stream(8'h00);
    chk({9'h0, ctl_kind}, {9'h0, KIND_I}, "kind");
    chk({2'h0, rx_seq, tx_seq, pf_bit, strobes[0], hits[0]}, 11'h4b, "i fields");
    $display("test info done");
  endtask
  task automatic t_sup();
    tc_val <= 8'hb1;
    for (int s = 0; s < 4; s++) begin
      q = '{8'h01, {3'h5, 1'b1, 2'(s), 2'b01}, 8'haa, 8'h55};
      run(0);
      chk({6'h0, ctl_kind, sup_type, rx_seq[2]}, {6'h0, KIND_S, 2'(s), 1'b1}, "sup");
      chk({4'h0, rx_seq, tx_seq, pf_bit}, 11'h51, "s fields");
      chk(11'(hits), 11'(s == 0), "rr trigger");
    end
    $display("test supervisory done");
  endtask
  task automatic t_unn();
    logic [7:0] code[19] = '{8'h83, 8'h0f, 8'h2f, 8'hcf, 8'h4f, 8'h6f, 8'h07, 8'h43, 8'h03, 8'h23, 8'h8f,
      8'haf, 8'h63, 8'h0f, 8'h07, 8'h03, 8'h87, 8'haf, 8'h43};
    hfc_utype_t ut[19] = '{UT_SNRM, UT_SARM, UT_SABM, UT_SNRME, UT_SARME, UT_SABME, UT_SIM, UT_DISC, UT_UI,
      UT_UP, UT_RSET, UT_XID, UT_UA, UT_DM, UT_RIM, UT_UI, UT_FRMR, UT_XID, UT_RD};
    logic pf;
    for (int i = 0; i < 19; i++) begin
      pf = i[0];
      resp_dir <= (i >= 12);
      q = '{8'h01, code[i] | {3'h0, pf, 4'h0}, 8'h11, 8'h22};
      run(0);
      chk({6'h0, un_type}, {6'h0, ut[i]}, "utype");
      chk({6'h0, ctl_kind, pf_bit, poll_flag, final_flag}, {6'h0, KIND_U, pf, pf & (i < 12), pf & (i >= 12)}, "u");
    end
    resp_dir <= 1'b0;
    $display("test unnumbered done");
  endtask
  task automatic t_trig();
    logic [7:0] ad[5] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h02};
    logic [7:0] ct[5] = '{8'h83, 8'h93, 8'h83, 8'h93, 8'h93};
    logic [7:0] cr[5] = '{8'hef, 8'hef, 8'hff, 8'hff, 8'hff};
    logic [4:0] ex = 5'b01011;
    ta_val <= 8'h01;
    ta_care <= 8'hff;
    tc_val <= 8'h93;
    for (int i = 0; i < 5; i++) begin
      tc_care <= cr[i];
      q = '{ad[i], ct[i], 8'h33, 8'h44};
      run(0);
      chk(11'(hits), {10'h0, ex[i]}, "pattern");
    end
    trig_enable <= 1'b0;
    q = '{8'h01, 8'h93, 8'h33, 8'h44};
    run(0);
    chk(11'(hits), 11'h0, "trigger off");
    trig_enable <= 1'b1;
    ta_care <= 8'h00;
    $display("test trigger done");
  endtask
  // The sink stalls long enough for the FIFO to fill, while the station sends slowly.
  task automatic t_odd();
    q = '{8'h01, 8'h10, 8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b};
    oct_ready <= 1'b0;
    hfc_line_station_i.gap = 2;
    fork
      begin
        repeat (900) @(posedge clk);
        chk({10'h0, line_ready}, 11'h0, "stall");
        oct_ready <= 1'b1;
      end
    join_none
    run(3);
    exp_stream(8'h03);
    hfc_line_station_i.gap = 0;
    $display("test odd length done");
  endtask
  task automatic t_bad();
    words.delete();
    hfc_line_station_i.put_oct(8'h00, 0);
    for (int i = 0; i < 8; i++) hfc_line_station_i.put_bit(HFC_FLAG[i], 1'b0);
    hfc_line_station_i.put_oct(8'h01, 8);
    hfc_line_station_i.put_oct(8'h11, 8);
    for (int i = 0; i < 7; i++) hfc_line_station_i.put_bit(1'b1, 1'b0);
    hfc_line_station_i.idle();
    wait_end();
    chk({7'h0, words[$][10:8], words[$][6]}, {7'h0, TAG_END, 1'b1}, "abort");
    q = '{8'h01};
    run(0);
    chk({6'h0, words[$][10:8], words[$][7:6]}, {6'h0, TAG_END, 2'b10}, "short");
    $display("test abort and short done");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_info();
    t_sup();
    t_unn();
    t_trig();
    t_odd();
    t_bad();
    test_done();
  end
endmodule
